// *** hdl/scrm_pkg.sv ***
// Purpose: shared constants of the serializer configuration/remap slice
// Assumes: 8-bit register port, 7-bit two-wire addresses
// Notes: offsets are the register addresses of the local register port
package scrm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int TADDR_W = 7;

    // register offsets
    localparam logic [7:0] OFS_GEN_CFG = 8'h03;
    localparam logic [7:0] OFS_MODE_SEL = 8'h05;
    localparam logic [7:0] OFS_DESER_ID = 8'h06;
    localparam logic [7:0] OFS_DESER_ALIAS = 8'h07;
    localparam logic [7:0] OFS_TARGET_ADDR = 8'h08;
    localparam logic [7:0] OFS_TARGET_ALIAS = 8'h09;

    // general configuration fields
    localparam int GEN_PLL_OVR_BIT = 1;
    localparam int GEN_EDGE_BIT = 0;
    localparam logic [7:0] GEN_CFG_RESET = 8'hC5;

    // payload mode select fields
    localparam int MODE_OVR_BIT = 5;
    localparam int MODE_CUR_BIT = 4;
    localparam int MODE_12HF_BIT = 3;
    localparam int MODE_10B_BIT = 2;
    localparam logic [1:0] MODE_RW_RESET = 2'h0;

    // identifier register fields
    localparam int ID_HOLD_BIT = 0;
    localparam logic [6:0] ADDR7_RESET = 7'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
endpackage

// *** hdl/scrm_alias_match.sv ***
// Purpose: compares one transaction address with one alias field
// Assumes: alias and replacement are 7-bit two-wire addresses
// Notes: a zero alias or a zero replacement disables the path
`timescale 1ns/1ps
`default_nettype none
module scrm_alias_match #(
    parameter int AW = 7
) (
    // address under test
    input wire logic [AW-1:0] txnAddr,
    // programmed fields
    input wire logic [AW-1:0] aliasAddr,
    input wire logic [AW-1:0] replaceAddr,
    // result
    output logic aliasHit,
    output logic pathEnabled
);
    // alias enabled only when nonzero
    assign aliasHit = (aliasAddr != '0) && (txnAddr == aliasAddr);
    // a zero replacement address blocks forwarding
    assign pathEnabled = (aliasAddr != '0) && (replaceAddr != '0);
endmodule
`default_nettype wire

// *** hdl/scrm_regs.sv ***
// Purpose: config registers and two-wire alias remap of a link serializer
// Assumes: register port and link inputs synchronous to clk
// Notes: remap decision is one cycle after the address byte
`timescale 1ns/1ps
`default_nettype none
module scrm_regs #(
    parameter int AW = scrm_pkg::TADDR_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // local register port
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [scrm_pkg::ADDR_W-1:0] regAddr,
    input wire logic [scrm_pkg::DATA_W-1:0] regWrData,
    output logic [scrm_pkg::DATA_W-1:0] regRdData,
    output logic regRdValid,
    // PLL clock source
    input wire logic modePinExtOsc,
    input wire logic pllModeRegExtOsc,
    output logic pllExtOscMode,
    // pixel capture edge
    output logic captureRisingEdge,
    // payload mode
    input wire logic bcModeValid,
    input wire logic bcMode12Hf,
    input wire logic bcMode10Bit,
    input wire logic pinMode12Hf,
    input wire logic pinMode10Bit,
    output logic mode12HfSel,
    output logic mode10BitSel,
    // back-channel identifier load
    input wire logic rxLock,
    input wire logic bcIdValid,
    input wire logic [AW-1:0] bcDeserId,
    // transaction remap
    input wire logic txnStart,
    input wire logic [AW-1:0] txnAddr,
    output logic fwdValid,
    output logic fwdToDeser,
    output logic fwdToTarget,
    output logic [AW-1:0] fwdAddr
);
    import scrm_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [7:0] genCfg;
    logic modeOverride;
    logic [1:0] modeRsvd;
    logic statusCurrent;
    logic [AW-1:0] deserId;
    logic identifierHold;
    logic [AW-1:0] deserAlias;
    logic [AW-1:0] targetAddr;
    logic [AW-1:0] targetAlias;
    logic wrGen;
    logic wrMode;
    logic wrId;
    logic wrDAlias;
    logic wrTAddr;
    logic wrTAlias;

    assign wrGen = regWrEn && (regAddr == OFS_GEN_CFG);
    assign wrMode = regWrEn && (regAddr == OFS_MODE_SEL);
    assign wrId = regWrEn && (regAddr == OFS_DESER_ID);
    assign wrDAlias = regWrEn && (regAddr == OFS_DESER_ALIAS);
    assign wrTAddr = regWrEn && (regAddr == OFS_TARGET_ADDR);
    assign wrTAlias = regWrEn && (regAddr == OFS_TARGET_ALIAS);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            genCfg <= GEN_CFG_RESET;
        end else if (wrGen) begin
            genCfg <= regWrData;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            modeOverride <= 1'b0;
            modeRsvd <= MODE_RW_RESET;
        end else if (wrMode) begin
            modeOverride <= regWrData[MODE_OVR_BIT];
            modeRsvd <= regWrData[7:6];
        end
    end

    // ------------------------------------------------------------------
    // identifier: software write or channel auto-load
    // ------------------------------------------------------------------
    logic autoLoad;
    assign autoLoad = rxLock && bcIdValid && !identifierHold;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            deserId <= ADDR7_RESET;
            identifierHold <= 1'b0;
        end else if (wrId) begin
            deserId <= regWrData[7:1];
            identifierHold <= regWrData[ID_HOLD_BIT];
        end else if (autoLoad) begin
            deserId <= bcDeserId;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            deserAlias <= ADDR7_RESET;
            targetAddr <= ADDR7_RESET;
            targetAlias <= ADDR7_RESET;
        end else begin
            if (wrDAlias) begin
                deserAlias <= regWrData[7:1];
            end
            if (wrTAddr) begin
                targetAddr <= regWrData[7:1];
            end
            if (wrTAlias) begin
                targetAlias <= regWrData[7:1];
            end
        end
    end

    // ------------------------------------------------------------------
    // clock source and capture edge
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pllExtOscMode <= 1'b0;
            captureRisingEdge <= 1'b1;
        end else begin
            if (genCfg[GEN_PLL_OVR_BIT]) begin
                pllExtOscMode <= pllModeRegExtOsc;
            end else begin
                pllExtOscMode <= modePinExtOsc;
            end
            captureRisingEdge <= genCfg[GEN_EDGE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // payload mode selection and status
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode12HfSel <= 1'b0;
            mode10BitSel <= 1'b0;
        end else if (modeOverride) begin
            mode12HfSel <= pinMode12Hf;
            mode10BitSel <= pinMode10Bit;
        end else if (bcModeValid) begin
            mode12HfSel <= bcMode12Hf;
            mode10BitSel <= bcMode10Bit;
        end
    end

    // current while locked after a received status; lost with the lock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            statusCurrent <= 1'b0;
        end else if (!rxLock) begin
            statusCurrent <= 1'b0;
        end else if (bcModeValid) begin
            statusCurrent <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // register read
    // ------------------------------------------------------------------
    logic [7:0] next_rdData;
    always_comb begin
        next_rdData = RD_UNMAPPED;
        case (regAddr)
            OFS_GEN_CFG: begin
                next_rdData = genCfg;
            end
            OFS_MODE_SEL: begin
                next_rdData = {modeRsvd, modeOverride,
                    statusCurrent,
                    mode12HfSel,
                    mode10BitSel, 2'b00};
            end
            OFS_DESER_ID: begin
                next_rdData = {deserId, identifierHold};
            end
            OFS_DESER_ALIAS: begin
                next_rdData = {deserAlias, 1'b0};
            end
            OFS_TARGET_ADDR: begin
                next_rdData = {targetAddr, 1'b0};
            end
            OFS_TARGET_ALIAS: begin
                next_rdData = {targetAlias, 1'b0};
            end
            default: begin
                next_rdData = RD_UNMAPPED;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= RD_UNMAPPED;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                regRdData <= next_rdData;
            end
        end
    end

    // ------------------------------------------------------------------
    // alias remap of the first address byte
    // ------------------------------------------------------------------
    logic deserHit;
    logic deserPathOn;
    logic targetHit;
    logic targetPathOn;

    scrm_alias_match #(.AW(AW)) uDeserMatch (
        .txnAddr(txnAddr),
        .aliasAddr(deserAlias),
        .replaceAddr(deserId),
        .aliasHit(deserHit),
        .pathEnabled(deserPathOn)
    );

    scrm_alias_match #(.AW(AW)) uTargetMatch (
        .txnAddr(txnAddr),
        .aliasAddr(targetAlias),
        .replaceAddr(targetAddr),
        .aliasHit(targetHit),
        .pathEnabled(targetPathOn)
    );

    // deserializer alias has priority when both aliases match
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fwdValid <= 1'b0;
            fwdToDeser <= 1'b0;
            fwdToTarget <= 1'b0;
            fwdAddr <= ADDR7_RESET;
        end else begin
            fwdValid <= txnStart;
            if (txnStart) begin
                if (deserHit) begin
                    fwdToDeser <= deserPathOn;
                    fwdToTarget <= 1'b0;
                    fwdAddr <= deserPathOn ? deserId : txnAddr;
                end else if (targetHit) begin
                    fwdToDeser <= 1'b0;
                    fwdToTarget <= targetPathOn;
                    fwdAddr <= targetPathOn ? targetAddr : txnAddr;
                end else begin
                    fwdToDeser <= 1'b0;
                    fwdToTarget <= 1'b0;
                    fwdAddr <= txnAddr;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    pll_source_a: assert property (
        genCfg[GEN_PLL_OVR_BIT] |=> pllExtOscMode == $past(pllModeRegExtOsc))
        else $error("pll mode not from register under override");

    pll_pin_a: assert property (
        !genCfg[GEN_PLL_OVR_BIT] |=> pllExtOscMode == $past(modePinExtOsc))
        else $error("pll mode not from pin");

    capture_edge_a: assert property (
        wrGen ##1 1'b1 |=> captureRisingEdge == $past(regWrData[0], 2))
        else $error("capture edge does not follow register");

    mode_override_a: assert property (
        (modeOverride && bcModeValid) |=> mode12HfSel == $past(pinMode12Hf))
        else $error("received mode bits not ignored");

    status_current_a: assert property (
        (rxLock && bcModeValid) ##1 rxLock [*2] |-> statusCurrent)
        else $error("mode status not current");

    id_autoload_a: assert property (
        (autoLoad && !wrId) |=> deserId == $past(bcDeserId))
        else $error("identifier not auto loaded");

    id_hold_a: assert property (
        (identifierHold && !wrId) |=> $stable(deserId))
        else $error("held identifier changed");

    deser_remap_a: assert property (
        (txnStart && deserHit && deserId != '0) |=>
            fwdValid && fwdToDeser && fwdAddr == $past(deserId))
        else $error("deserializer alias not remapped");

    zero_block_a: assert property (
        (txnStart && (targetAlias == '0 || targetAddr == '0))
            |=> !fwdToTarget)
        else $error("target forwarded with zero field");

    no_match_a: assert property (
        (txnStart && !deserHit && !targetHit) |=>
            fwdAddr == $past(txnAddr) && !fwdToDeser && !fwdToTarget)
        else $error("unmatched address remapped");
endmodule
`default_nettype wire

// *** dv/scrm_far_end.sv ***
// Purpose: far-end model of the remote deserializer back channel
// Assumes: bench calls its tasks; outputs change on clk rising edge
// Notes: idle data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module scrm_far_end (
    // clock
    input wire logic clk,
    // back channel
    output logic rxLock,
    output logic bcIdValid,
    output logic [6:0] bcDeserId,
    output logic bcModeValid,
    output logic bcMode12Hf,
    output logic bcMode10Bit
);
    initial begin
        rxLock = 1'b0;
        bcIdValid = 1'b0;
        bcDeserId = 7'h55;
        bcModeValid = 1'b0;
        bcMode12Hf = 1'b0;
        bcMode10Bit = 1'b1;
    end
    task automatic set_lock(input logic v);
        @(posedge clk);
        rxLock <= v;
    endtask
    task automatic send_id(input logic [6:0] id);
        @(posedge clk);
        bcIdValid <= 1'b1;
        bcDeserId <= id;
        @(posedge clk);
        bcIdValid <= 1'b0;
        bcDeserId <= ~id;
    endtask
    task automatic send_mode(input logic m12, input logic m10);
        @(posedge clk);
        bcModeValid <= 1'b1;
        bcMode12Hf <= m12;
        bcMode10Bit <= m10;
        @(posedge clk);
        bcModeValid <= 1'b0;
        bcMode12Hf <= ~m12;
        bcMode10Bit <= ~m10;
    endtask
endmodule
`default_nettype wire

// *** dv/test_serializer_cfg_i2c_remap_regs.sv ***
// Purpose: self-checking bench of the configuration and remap slice
// Assumes: far-end model drives the back channel
// Notes: random values from an xorshift starting at 94
`timescale 1ns/1ps
`default_nettype none
module test_serializer_cfg_i2c_remap_regs;
    import scrm_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0;
    logic regWrEn = 0, regRdEn = 0, regRdValid, txnStart = 0;
    logic [7:0] regAddr = 0, regWrData = 0, regRdData, rd;
    logic modePinExtOsc = 0, pllModeRegExtOsc = 0, pllExtOscMode;
    logic captureRisingEdge, pinMode12Hf = 0, pinMode10Bit = 0;
    logic mode12HfSel, mode10BitSel, rxLock, bcIdValid;
    logic bcModeValid, bcMode12Hf, bcMode10Bit;
    logic fwdValid, fwdToDeser, fwdToTarget;
    logic [6:0] bcDeserId, txnAddr = 0, fwdAddr, dAl, tAl, tgt, id, a, b;
    int mismatches = 0, n_tests = 0;
    logic [31:0] seed = 32'd94;
    always #5 clk = ~clk;
    scrm_regs u_scrm_regs (.clk(clk), .arst_n(arst_n), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .regRdValid(regRdValid),
        .modePinExtOsc(modePinExtOsc), .pllModeRegExtOsc(pllModeRegExtOsc),
        .pllExtOscMode(pllExtOscMode), .captureRisingEdge(captureRisingEdge),
        .bcModeValid(bcModeValid), .bcMode12Hf(bcMode12Hf),
        .bcMode10Bit(bcMode10Bit), .pinMode12Hf(pinMode12Hf),
        .pinMode10Bit(pinMode10Bit), .mode12HfSel(mode12HfSel),
        .mode10BitSel(mode10BitSel), .rxLock(rxLock), .bcIdValid(bcIdValid),
        .bcDeserId(bcDeserId), .txnStart(txnStart), .txnAddr(txnAddr),
        .fwdValid(fwdValid), .fwdToDeser(fwdToDeser),
        .fwdToTarget(fwdToTarget), .fwdAddr(fwdAddr));
    scrm_far_end u_scrm_far_end (.clk(clk), .rxLock(rxLock),
        .bcIdValid(bcIdValid), .bcDeserId(bcDeserId),
        .bcModeValid(bcModeValid), .bcMode12Hf(bcMode12Hf),
        .bcMode10Bit(bcMode10Bit));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [6:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[6:0];
    endfunction
    // expected {toDeser, toTarget, address} from the shadow fields
    function automatic logic [8:0] remap(input logic [6:0] x);
        if (dAl != 0 && x == dAl)
            return (id != 0) ? {2'b10, id} : {2'b00, x};
        if (tAl != 0 && x == tAl)
            return (tgt != 0) ? {2'b01, tgt} : {2'b00, x};
        return {2'b00, x};
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [8:0] s, e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        regWrEn <= 1'b1;
        regAddr <= ad;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'b0;
        regWrData <= ~d;
    endtask
    task automatic rdchk(input logic [7:0] ad, input logic [7:0] e);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= ad;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        chk("regRdValid", {8'h00, regRdValid}, 9'h001);
        chk("regRdData", {1'b0, regRdData}, {1'b0, e});
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic txn(input logic [6:0] x);
        @(posedge clk);
        txnStart <= 1'b1;
        txnAddr <= x;
        @(posedge clk);
        txnStart <= 1'b0;
        txnAddr <= ~x;
        #1;
        chk("fwdValid", {8'h00, fwdValid}, 9'h001);
        chk("fwd", {fwdToDeser, fwdToTarget, fwdAddr}, remap(x));
    endtask
    initial begin
        #200000;
        mismatches++;
        wrap_up();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk("captureRisingEdge", {8'h00, captureRisingEdge}, 9'h1);
        rdchk(OFS_GEN_CFG, 8'hC5);
        rdchk(OFS_MODE_SEL, 8'h00);
        rdchk(OFS_DESER_ID, 8'h00);
        rdchk(OFS_DESER_ALIAS, 8'h00);
        rdchk(OFS_TARGET_ADDR, 8'h00);
        rdchk(OFS_TARGET_ALIAS, 8'h00);
        rdchk(8'h0A, 8'h00);
        modePinExtOsc <= 1'b1;
        settle();
        chk("pllExtOscMode", {8'h00, pllExtOscMode}, 9'h001);
        wr(OFS_GEN_CFG, 8'hC7);
        settle();
        chk("pllExtOscMode", {8'h00, pllExtOscMode}, 9'h000);
        @(posedge clk);
        pllModeRegExtOsc <= 1'b1;
        modePinExtOsc <= 1'b0;
        settle();
        chk("pllExtOscMode", {8'h00, pllExtOscMode}, 9'h001);
        wr(OFS_GEN_CFG, 8'hC4);
        settle();
        chk("captureRisingEdge", {8'h00, captureRisingEdge}, 9'h0);
        chk("pllExtOscMode", {8'h00, pllExtOscMode}, 9'h000);
        u_scrm_far_end.set_lock(1'b1);
        u_scrm_far_end.send_mode(1'b1, 1'b0);
        settle();
        chk("mode12HfSel", {8'h00, mode12HfSel}, 9'h001);
        rdchk(OFS_MODE_SEL, 8'h18);
        pinMode10Bit <= 1'b1;
        wr(OFS_MODE_SEL, 8'h2F);
        u_scrm_far_end.send_mode(1'b1, 1'b0);
        settle();
        chk("mode10BitSel", {8'h00, mode10BitSel}, 9'h001);
        rdchk(OFS_MODE_SEL, 8'h34);
        u_scrm_far_end.set_lock(1'b0);
        settle();
        rdchk(OFS_MODE_SEL, 8'h24);
        u_scrm_far_end.set_lock(1'b1);
        id = rnd() | 7'h01;
        u_scrm_far_end.send_id(id);
        settle();
        rdchk(OFS_DESER_ID, {id, 1'b0});
        id = id ^ 7'h22;
        wr(OFS_DESER_ID, {id, 1'b1});
        u_scrm_far_end.send_id(~id);
        settle();
        rdchk(OFS_DESER_ID, {id, 1'b1});
        dAl = rnd() | 7'h01;
        tAl = dAl ^ 7'h40;
        tgt = rnd() | 7'h02;
        wr(OFS_DESER_ALIAS, {dAl, 1'b0});
        wr(OFS_TARGET_ADDR, {tgt, 1'b0});
        wr(OFS_TARGET_ALIAS, {tAl, 1'b0});
        for (int i = 0; i < 12; i++) begin
            a = rnd();
            b = (a[1:0] == 2'h0) ? dAl : (a[1:0] == 2'h1) ? tAl : rnd();
            txn(b);
        end
        // zero replacement, zero identifier, zero alias
        tgt = 0;
        wr(OFS_TARGET_ADDR, 8'h00);
        txn(tAl);
        id = 0;
        wr(OFS_DESER_ID, 8'h01);
        txn(dAl);
        a = dAl;
        dAl = 0;
        wr(OFS_DESER_ALIAS, 8'h00);
        txn(a);
        wrap_up();
    end
endmodule
`default_nettype wire
